// File: src/pwmst_pkg.sv
// Package for the PWM steering and auto-restart output stage.
// Assumes a 32-bit AXI4-Lite register bus on a single clock.
package pwmst_pkg;

  // Register byte offsets
  localparam logic [7:0] PWMST_OFF_STEER  = 8'h00;
  localparam logic [7:0] PWMST_OFF_MODE   = 8'h04;
  localparam logic [7:0] PWMST_OFF_SHDN   = 8'h08;
  localparam logic [7:0] PWMST_OFF_CTRL   = 8'h0c;
  localparam logic [7:0] PWMST_OFF_STAT   = 8'h10;
  localparam logic [7:0] PWMST_OFF_IEN    = 8'h14;
  localparam logic [7:0] PWMST_OFF_ICLR   = 8'h18;
  localparam logic [7:0] PWMST_OFF_PORT   = 8'h1c;

  // Steering register layout and reset value
  localparam int         PWMST_STEER_W    = 5;
  localparam int         PWMST_SYNC_BIT   = 4;
  localparam logic [4:0] PWMST_STEER_RST  = 5'h01;

  // Mode register layout: [3:0] mode select, [5:4] output config
  localparam logic [1:0] PWMST_MODE_PWM   = 2'h3;
  localparam logic [1:0] PWMST_CFG_SINGLE = 2'h0;

  // Shutdown register layout: [1:0] pair B/D state, [3:2] pair A/C state,
  // [4] software shutdown, [7] event flag
  localparam int         PWMST_FLAG_BIT   = 7;
  localparam logic [1:0] PWMST_SS_LOW     = 2'h0;
  localparam logic [1:0] PWMST_SS_HIGH    = 2'h1;
  localparam logic [1:0] PWMST_SS_TRI     = 2'h2;

  // Control register: [0] restart auto enable
  localparam int         PWMST_RSTEN_BIT  = 0;

  // Interrupt status bits
  localparam int         PWMST_IRQ_W      = 2;
  localparam int         PWMST_IRQ_SHDN   = 0;
  localparam int         PWMST_IRQ_RESUME = 1;

  // AXI responses
  localparam logic [1:0] PWMST_RESP_OKAY  = 2'h0;
  localparam logic [1:0] PWMST_RESP_SLV   = 2'h2;

endpackage : pwmst_pkg

// File: src/pwmst_cfg_if.sv
// Configuration bundle from the register file to the output stage.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface pwmst_cfg_if;
  logic [4:0] steer;
  logic [3:0] mode_sel;
  logic [1:0] out_cfg;
  logic [1:0] ss_ac;
  logic [1:0] ss_bd;
  logic       restart_en;
  logic       shdn_active;
  logic       steer_wr;
  logic [3:0] steer_act;
  modport regs  (output steer, mode_sel, out_cfg, ss_ac, ss_bd,
                 restart_en, steer_wr, input shdn_active, steer_act);
  modport stage (input steer, mode_sel, out_cfg, ss_ac, ss_bd,
                 restart_en, steer_wr, output shdn_active, steer_act);
endinterface : pwmst_cfg_if

// File: src/pwmst_stage.sv
// Steering and shutdown output stage.
// Assumes sync inputs: raw waveform, period start, shutdown level.
`timescale 1ns/10ps
module pwmst_stage (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // Waveform and shutdown
  input  wire logic i_pwm,
  input  wire logic i_period,
  input  wire logic i_shdn_lvl,
  input  wire logic i_sw_shdn,
  input  wire logic i_flag_clr,
  input  wire logic [3:0] i_port,
  // Configuration
  pwmst_cfg_if.stage cfg,
  // Pin drive
  output logic [3:0] o_pin,
  output logic [3:0] o_pin_oe_n
);
  import pwmst_pkg::*;

  typedef struct packed {
    logic [3:0] act;
    logic [3:0] pend;
    logic       pend_v;
    logic       flag;
    logic       hold;
    logic [3:0] pin;
    logic [3:0] oe_n;
  } pwmst_stage_s;

  pwmst_stage_s st_r;
  pwmst_stage_s st_nxt;
  logic         steer_on;
  logic [1:0]   ss;
  logic         wave;

  always_comb begin
    st_nxt   = st_r;
    steer_on = (cfg.mode_sel[3:2] == PWMST_MODE_PWM) &&
               (cfg.out_cfg == PWMST_CFG_SINGLE);
    if (cfg.steer_wr) begin
      if (cfg.steer[PWMST_SYNC_BIT]) begin
        st_nxt.pend   = cfg.steer[3:0];
        st_nxt.pend_v = 1'b1;
      end else begin
        st_nxt.act    = cfg.steer[3:0];
        st_nxt.pend_v = 1'b0;
      end
    end else if (st_r.pend_v && i_period) begin
      st_nxt.act    = st_r.pend;
      st_nxt.pend_v = 1'b0;
    end
    // level shutdown sets flag; held while level
    if (i_shdn_lvl || i_sw_shdn) begin
      st_nxt.flag = 1'b1;
    end else if (cfg.restart_en || i_flag_clr) begin
      st_nxt.flag = 1'b0;
    end
    if (st_nxt.flag) begin
      st_nxt.hold = 1'b1;
    end else if (i_period) begin
      st_nxt.hold = 1'b0;
    end
    wave = i_pwm ^ cfg.mode_sel[0];
    for (int i = 0; i < 4; i++) begin
      ss = (i == 0 || i == 2) ? cfg.ss_ac : cfg.ss_bd;
      if (steer_on && st_r.act[i]) begin
        if (st_r.flag || st_r.hold) begin
          st_nxt.pin[i]  = (ss == PWMST_SS_HIGH);
          st_nxt.oe_n[i] = (ss == PWMST_SS_TRI);
        end else begin
          st_nxt.pin[i]  = ((i == 1 || i == 3) ? (i_pwm ^ cfg.mode_sel[1])
                                                : wave);
          st_nxt.oe_n[i] = 1'b0;
        end
      end else begin
        st_nxt.pin[i]  = i_port[i];
        st_nxt.oe_n[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{act: PWMST_STEER_RST[3:0], pend: 4'h0, pend_v: 1'b0,
                flag: 1'b0, hold: 1'b0, pin: 4'h0, oe_n: 4'hf};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg.shdn_active = st_r.flag;
  assign cfg.steer_act   = st_r.act;
  assign o_pin           = st_r.pin;
  assign o_pin_oe_n      = st_r.oe_n;

endmodule : pwmst_stage

// File: src/pwmst_top.sv
// Top: AXI4-Lite register file, interrupts and the output stage.
// Assumes external waveform, period and shutdown inputs are asynchronous.
`timescale 1ns/10ps
module pwmst_top (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // AXI4-Lite write
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Waveform source and shutdown
  input  wire logic        i_pwm,
  input  wire logic        i_period,
  input  wire logic        i_shdn,
  // Pins
  output logic [3:0]       o_pwm_out,
  output logic [3:0]       o_pwm_out_oe_n,
  output logic             o_irq
);
  import pwmst_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic [2:0] in_s1_r;
  logic [2:0] in_s2_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_r <= 3'h0;
      in_s2_r <= 3'h0;
    end else begin
      in_s1_r <= {i_shdn, i_period, i_pwm};
      in_s2_r <= in_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register state

  typedef struct packed {
    logic [4:0]             steer;
    logic [5:0]             mode;
    logic [3:0]             ss;
    logic                   sw_shdn;
    logic                   rsten;
    logic [3:0]             port;
    logic [PWMST_IRQ_W-1:0] stat;
    logic [PWMST_IRQ_W-1:0] ien;
    logic                   flag_d;
    logic                   aw_v;
    logic                   awready;
    logic                   wready;
    logic [7:0]             aw_a;
    logic                   w_v;
    logic [31:0]            w_d;
    logic [3:0]             w_s;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   steer_wr;
    logic                   flag_clr;
    logic                   irq;
  } pwmst_regs_s;

  pwmst_regs_s r_r;
  pwmst_regs_s r_nxt;
  pwmst_cfg_if cfg_bus ();

  logic                   do_wr;
  logic [PWMST_IRQ_W-1:0] ev;
  logic [31:0]            rd;
  logic                   rd_ok;

  always_comb begin
    r_nxt          = r_r;
    r_nxt.steer_wr = 1'b0;
    r_nxt.flag_clr = 1'b0;
    rd             = 32'h0;
    rd_ok          = 1'b1;
    // Address and data may arrive in either order
    if (i_awvalid && r_r.awready) begin
      r_nxt.aw_v = 1'b1;
      r_nxt.aw_a = i_awaddr;
    end
    if (i_wvalid && r_r.wready) begin
      r_nxt.w_v = 1'b1;
      r_nxt.w_d = i_wdata;
      r_nxt.w_s = i_wstrb;
    end
    do_wr = r_r.aw_v && r_r.w_v && !r_r.bvalid;
    // Events: shutdown entry and resume (flag cleared by auto-restart or by software)
    ev = {r_r.flag_d && !cfg_bus.shdn_active,
          !r_r.flag_d && cfg_bus.shdn_active};
    r_nxt.flag_d = cfg_bus.shdn_active;
    r_nxt.stat   = r_r.stat | ev;
    if (do_wr) begin
      r_nxt.aw_v   = 1'b0;
      r_nxt.w_v    = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = PWMST_RESP_OKAY;
      if (r_r.w_s[0]) begin
        unique case (r_r.aw_a)
          PWMST_OFF_STEER: begin
            r_nxt.steer    = r_r.w_d[PWMST_STEER_W-1:0];
            r_nxt.steer_wr = 1'b1;
          end
          PWMST_OFF_MODE: r_nxt.mode = r_r.w_d[5:0];
          PWMST_OFF_SHDN: begin
            r_nxt.ss      = r_r.w_d[3:0];
            r_nxt.sw_shdn = r_r.w_d[4];
            // Writing zero to the flag clears it unless held
            r_nxt.flag_clr = !r_r.w_d[PWMST_FLAG_BIT];
          end
          PWMST_OFF_CTRL: r_nxt.rsten = r_r.w_d[PWMST_RSTEN_BIT];
          PWMST_OFF_IEN:  r_nxt.ien   = r_r.w_d[PWMST_IRQ_W-1:0];
          // Set wins over clear
          PWMST_OFF_ICLR: r_nxt.stat  = (r_r.stat &
                                         ~r_r.w_d[PWMST_IRQ_W-1:0]) | ev;
          PWMST_OFF_PORT: r_nxt.port  = r_r.w_d[3:0];
          PWMST_OFF_STAT: ;
          default: r_nxt.bresp = PWMST_RESP_SLV;
        endcase
      end
    end
    if (r_r.bvalid && i_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    // Reads
    unique case (i_araddr)
      PWMST_OFF_STEER: rd = {27'h0, r_r.steer};
      PWMST_OFF_MODE:  rd = {26'h0, r_r.mode};
      PWMST_OFF_SHDN:  rd = {24'h0, cfg_bus.shdn_active, 2'h0,
                             r_r.sw_shdn, r_r.ss};
      PWMST_OFF_CTRL:  rd = {31'h0, r_r.rsten};
      PWMST_OFF_STAT:  rd = {30'h0, r_r.stat};
      PWMST_OFF_IEN:   rd = {30'h0, r_r.ien};
      PWMST_OFF_ICLR:  rd = 32'h0;
      PWMST_OFF_PORT:  rd = {24'h0, cfg_bus.steer_act, r_r.port};
      default:         rd_ok = 1'b0;
    endcase
    r_nxt.arready = 1'b0;
    if (i_arvalid && !r_r.arready && !r_r.rvalid) begin
      r_nxt.arready = 1'b1;
      r_nxt.rvalid  = 1'b1;
      r_nxt.rdata   = rd_ok ? rd : 32'h0;
      r_nxt.rresp   = rd_ok ? PWMST_RESP_OKAY : PWMST_RESP_SLV;
    end
    if (r_r.rvalid && i_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    // Ready flags registered so the ports come from flops
    r_nxt.awready = !r_nxt.aw_v;
    r_nxt.wready  = !r_nxt.w_v;
    r_nxt.irq = |(r_nxt.stat & r_r.ien);
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_r       <= '0;
      r_r.steer <= PWMST_STEER_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration towards the stage

  assign cfg_bus.steer      = r_r.steer;
  assign cfg_bus.steer_wr   = r_r.steer_wr;
  assign cfg_bus.mode_sel   = r_r.mode[3:0];
  assign cfg_bus.out_cfg    = r_r.mode[5:4];
  assign cfg_bus.ss_ac      = r_r.ss[3:2];
  assign cfg_bus.ss_bd      = r_r.ss[1:0];
  assign cfg_bus.restart_en = r_r.rsten;

  // non-steered pins are driven whenever out of reset; their level comes from the port bits
  pwmst_stage u_stage (
    .i_mclk     (i_mclk),
    .i_rst_n    (rst_n),
    .i_pwm      (in_s2_r[0]),
    .i_period   (in_s2_r[1]),
    .i_shdn_lvl (in_s2_r[2]),
    .i_sw_shdn  (r_r.sw_shdn),
    .i_flag_clr (r_r.flag_clr),
    .i_port     (r_r.port),
    .cfg        (cfg_bus.stage),
    .o_pin      (o_pwm_out),
    .o_pin_oe_n (o_pwm_out_oe_n)
  );

  assign o_awready = r_r.awready;
  assign o_wready  = r_r.wready;
  assign o_bvalid  = r_r.bvalid;
  assign o_bresp   = r_r.bresp;
  assign o_arready = r_r.arready;
  assign o_rvalid  = r_r.rvalid;
  assign o_rdata   = r_r.rdata;
  assign o_rresp   = r_r.rresp;
  assign o_irq     = r_r.irq;

endmodule : pwmst_top

// File: test/pwmst_sva.sv
// Checker for bus and shutdown relations at the steering top ports.
// Assumes a bind to pwmst_top and a single clock domain.
`timescale 1ns/10ps
module pwmst_sva (
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  // Register bus
  input wire logic [7:0]  i_awaddr,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [7:0]  i_araddr,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  // Shutdown and pins
  input wire logic        i_shdn,
  input wire logic [3:0]  o_pwm_out,
  input wire logic [3:0]  o_pwm_out_oe_n
);
  import pwmst_pkg::*;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////
  AST_AR_TAKE: assert property (i_arvalid && !o_arready && !o_rvalid
    |=> o_arready) else $error("read not accepted");
  AST_AR_PULSE: assert property (o_arready |=> !o_arready)
    else $error("arready longer than one cycle");
  AST_AR_RVALID: assert property (o_arready |-> o_rvalid)
    else $error("rvalid not with arready");
  AST_R_HOLD: assert property (o_rvalid && !i_rready
    |=> o_rvalid && $stable(o_rdata)) else $error("read data dropped");
  AST_RD_SLV: assert property (o_arready && i_araddr > 8'h1c
    |-> o_rresp == PWMST_RESP_SLV && o_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_AW_BUSY: assert property (i_awvalid && o_awready |=> !o_awready)
    else $error("second address accepted");
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  AST_B_RESP: assert property (i_awvalid && o_awready && i_wvalid
    && o_wready |-> ##2 o_bvalid && o_bresp == ($past(i_awaddr, 2)
    > 8'h1c ? PWMST_RESP_SLV : PWMST_RESP_OKAY))
    else $error("write response wrong");
  AST_SHDN_FREEZE:
    assert property ((i_shdn && !i_wvalid && !o_bvalid)[*6]
    |-> $stable(o_pwm_out) && $stable(o_pwm_out_oe_n))
    else $error("pins moved during shutdown");
endmodule : pwmst_sva

bind pwmst_top pwmst_sva chk_u (
  .i_mclk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wvalid,
  .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
  .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_shdn,
  .o_pwm_out, .o_pwm_out_oe_n
);

// File: test/pwmst_load.sv
// Power stage load seen by the four output pins.
// Assumes gate resistors pull released pins low.
`timescale 1ns/10ps
module pwmst_load (
  // Pin drive
  input  wire logic [3:0] i_drv,
  input  wire logic [3:0] i_drv_oe_n,
  // Resolved level
  output logic      [3:0] o_lvl
);
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_lvl[k] = i_drv_oe_n[k] ? 1'h0 : i_drv[k];
    end
  end
endmodule : pwmst_load

// File: test/tb.sv
// Bench for the steering and auto-restart output stage.
// Assumes the checker is bound and the load model resolves pins.
`timescale 1ns/10ps
module tb;
  import pwmst_pkg::*;
  logic        i_mclk = 1'h0, i_rst_n = 1'h0;
  logic [7:0]  i_awaddr = 8'h0, i_araddr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0]  i_wstrb = 4'hf;
  logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
  logic        i_arvalid = 1'h0, i_rready = 1'h0;
  logic        i_pwm = 1'h0, i_period = 1'h0, i_shdn = 1'h0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0]  o_bresp, o_rresp, rs;
  logic [31:0] o_rdata, rv;
  logic [3:0]  o_pwm_out, o_pwm_out_oe_n, lvl;
  int          err_count = 0, tests_run = 0;

  pwmst_top dut_u (
    .i_mclk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .i_pwm, .i_period, .i_shdn, .o_pwm_out, .o_pwm_out_oe_n,
    .o_irq
  );
  pwmst_load ld_u (.i_drv(o_pwm_out), .i_drv_oe_n(o_pwm_out_oe_n),
    .o_lvl(lvl));

  always #4 i_mclk = ~i_mclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(inout int n);
    @(posedge i_mclk);
    n++;
    if (n > 50) begin
      err_count++;
      print_verdict();
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      tick(n);
      if (o_awready && i_awvalid) i_awvalid <= 1'h0;
      if (o_wready && i_wvalid) i_wvalid <= 1'h0;
    end while (!o_bvalid);
    rs = o_bresp;
    i_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      tick(n);
    end while (!o_rvalid);
    rv = o_rdata;
    rs = o_rresp;
    i_arvalid <= 1'h0;
    i_rready <= 1'h0;
  endtask : rd

  // Pins settle at most four clocks after any input
  task automatic see(input logic [31:0] exp);
    repeat (5) @(posedge i_mclk);
    chk({24'h0, o_pwm_out_oe_n, lvl}, exp);
  endtask : see

  task automatic per;
    i_period <= 1'h1;
    @(posedge i_mclk);
    i_period <= 1'h0;
  endtask : per
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    see(32'h00);
    rd(PWMST_OFF_STEER);
    chk(rv, 32'h01);
    wr(PWMST_OFF_STEER, 32'hff);
    rd(PWMST_OFF_STEER);
    chk(rv, 32'h1f);
    i_wstrb <= 4'he;
    wr(PWMST_OFF_STEER, 32'h00);
    i_wstrb <= 4'hf;
    rd(PWMST_OFF_STEER);
    chk(rv, 32'h1f);
    wr(8'h24, 32'h01);
    chk({30'h0, rs}, 32'h2);
    rd(8'h20);
    chk({rs, rv[29:0]}, 32'h80000000);
  endtask : t_reset

  task automatic t_steer;
    wr(PWMST_OFF_MODE, 32'h0c);
    wr(PWMST_OFF_PORT, 32'h0a);
    wr(PWMST_OFF_STEER, 32'h05);
    i_pwm <= 1'h1;
    see(32'h0f);
    i_pwm <= 1'h0;
    see(32'h0a);
    wr(PWMST_OFF_MODE, 32'h0d);
    see(32'h0f);
    wr(PWMST_OFF_MODE, 32'h1d);
    see(32'h0a);
    wr(PWMST_OFF_PORT, 32'h00);
    wr(PWMST_OFF_STEER, 32'h0f);
    wr(PWMST_OFF_MODE, 32'h0e);
    see(32'h0a);
  endtask : t_steer

  task automatic t_sync;
    wr(PWMST_OFF_MODE, 32'h0c);
    i_pwm <= 1'h1;
    see(32'h0f);
    wr(PWMST_OFF_STEER, 32'h12);
    see(32'h0f);
    per();
    see(32'h02);
    rd(PWMST_OFF_PORT);
    chk(rv, 32'h20);
    wr(PWMST_OFF_STEER, 32'h03);
    see(32'h03);
  endtask : t_sync

  task automatic t_shdn;
    i_pwm <= 1'h0;
    wr(PWMST_OFF_PORT, 32'h0c);
    wr(PWMST_OFF_SHDN, 32'h06);
    wr(PWMST_OFF_CTRL, 32'h01);
    wr(PWMST_OFF_IEN, 32'h01);
    see(32'h0c);
    i_shdn <= 1'h1;
    see(32'h2d);
    chk({31'h0, o_irq}, 32'h1);
    rd(PWMST_OFF_SHDN);
    chk(rv, 32'h86);
    i_pwm <= 1'h1;
    see(32'h2d);
    wr(PWMST_OFF_ICLR, 32'h01);
    rd(PWMST_OFF_STAT);
    chk({rv[30:0], o_irq}, 32'h0);
    i_shdn <= 1'h0;
    see(32'h2d);
    rd(PWMST_OFF_SHDN);
    chk({rv[30:0], o_irq}, 32'h0c);
    per();
    see(32'h0f);
    wr(PWMST_OFF_IEN, 32'h03);
    rd(PWMST_OFF_STAT);
    chk({rv[30:0], o_irq}, 32'h5);
    wr(PWMST_OFF_ICLR, 32'h03);
    rd(PWMST_OFF_ICLR);
    chk({rv[30:0], o_irq}, 32'h0);
  endtask : t_shdn

  task automatic t_latch;
    wr(PWMST_OFF_CTRL, 32'h00);
    wr(PWMST_OFF_SHDN, 32'h01);
    i_shdn <= 1'h1;
    see(32'h0e);
    i_shdn <= 1'h0;
    per();
    see(32'h0e);
    rd(PWMST_OFF_SHDN);
    chk(rv, 32'h81);
    wr(PWMST_OFF_SHDN, 32'h01);
    per();
    see(32'h0f);
    wr(PWMST_OFF_SHDN, 32'h10);
    see(32'h0c);
    rd(PWMST_OFF_SHDN);
    chk(rv, 32'h90);
    wr(PWMST_OFF_SHDN, 32'h00);
    per();
    see(32'h0f);
  endtask : t_latch

  task automatic t_rerst;
    @(posedge i_mclk);
    i_rst_n <= 1'h0;
    repeat (4) @(posedge i_mclk);
    chk({27'h0, o_irq, o_pwm_out_oe_n}, 32'h0f);
    i_rst_n <= 1'h1;
    repeat (4) @(posedge i_mclk);
    rd(PWMST_OFF_STEER);
    chk(rv, 32'h01);
    rd(PWMST_OFF_PORT);
    chk(rv, 32'h10);
  endtask : t_rerst

  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    repeat (6) @(posedge i_mclk);
    t_reset();
    t_steer();
    t_sync();
    t_shdn();
    t_latch();
    t_rerst();
    print_verdict();
  end
endmodule : tb
